// File: verification/fault_table_logger_bench.sv
`timescale 1ns/10ps
module fault_table_logger_bench;
	import ftl_pkg::*;
	// ----------------------------------------
	// Signals
	// ----------------------------------------
	logic clk_i = 1'b0, rst_i = 1'b1, wb_cyc_i = 1'b0, wb_stb_i = 1'b0;
	logic wb_we_i = 1'b0, wb_ack_o, dev_evt_valid_i, dev_evt_ready_o;
	logic [7:0] wb_adr_i = 8'h00, dev_evt_sub_i, sub_stat_id_i, pres_id_i;
	logic [3:0] wb_sel_i = 4'h0, dev_evt_type_i, dev_evt_rrack_i;
	logic [3:0] dev_evt_rslot_i, flt;
	logic [31:0] wb_dat_i = 32'h0, wb_dat_o, q;
	logic ctrl_lost_i = 1'b0, ctrl_added_i = 1'b0, ctrl_fault_i = 1'b0;
	logic bus_fault_i = 1'b0, resync_i = 1'b0, sub_stat_valid_i;
	logic pres_valid_i, pres_present_i;
	logic [31:0] pt_consumed_i = '1, pt_circuit_fault_i = '0;
	logic [31:0] pt_hi_alarm_i = '0, pt_lo_alarm_i = '0;
	logic [31:0] point_fault_o, no_fault_indication_o;
	logic [31:0] high_alarm_indication_o, low_alarm_indication_o;
	logic [255:0] sub_fault_o;
	logic bus_controller_unit_fault_o, log_full_o, fault_logged_flag_o;
	logic io_fault_occurred_flag_o, bus_or_controller_fault_flag_o;
	logic controller_lost_flag_o, controller_added_flag_o;
	int n_errors = 0;
	int compares = 0;
	// Status cases: remote io, bus fail, lost, module fault, expected fault
	logic [4:0] tab [5] = '{5'h10, 5'h13, 5'h19, 5'h15, 5'h02};
	logic [3:0] types [4] = '{FTL_T_CTRL_LOST, FTL_T_BUS_FAULT,
		FTL_T_RESYNC, FTL_T_CTRL_ADDED};
	// Clock, 40 ns period
	always #20 clk_i = ~clk_i;
	ftl_top u_ftl_top (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i,
		.wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .ctrl_lost_i,
		.ctrl_added_i, .ctrl_fault_i, .bus_fault_i, .resync_i,
		.dev_evt_valid_i, .dev_evt_ready_o, .dev_evt_type_i, .dev_evt_sub_i,
		.dev_evt_rrack_i, .dev_evt_rslot_i, .sub_stat_valid_i,
		.sub_stat_id_i, .sub_remote_io_i(flt[3]), .sub_bus_fail_i(flt[2]),
		.sub_lost_i(flt[1]), .sub_module_fault_i(flt[0]), .pres_valid_i,
		.pres_id_i, .pres_present_i, .pt_consumed_i, .pt_circuit_fault_i,
		.pt_hi_alarm_i, .pt_lo_alarm_i, .point_fault_o,
		.no_fault_indication_o, .high_alarm_indication_o,
		.low_alarm_indication_o, .sub_fault_o, .bus_controller_unit_fault_o,
		.log_full_o, .fault_logged_flag_o, .io_fault_occurred_flag_o,
		.bus_or_controller_fault_flag_o, .controller_lost_flag_o,
		.controller_added_flag_o);
	ftl_sub_model u_ftl_sub_model (.clk_i, .ready_i(dev_evt_ready_o),
		.valid_o(dev_evt_valid_i), .type_o(dev_evt_type_i),
		.sub_o(dev_evt_sub_i), .rrack_o(dev_evt_rrack_i),
		.rslot_o(dev_evt_rslot_i), .stat_valid_o(sub_stat_valid_i),
		.stat_id_o(sub_stat_id_i), .flt_o(flt), .pres_valid_o(pres_valid_i),
		.pres_id_o(pres_id_i), .present_o(pres_present_i));
	// ----------------------------------------
	// Tasks
	// ----------------------------------------
	task end_of_test;
		$display("compares %0d mismatches %0d", compares, n_errors);
		if (n_errors == 0 && compares > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask
	task chk(input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			n_errors++;
			$display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	// Classic cycle; read data taken at the edge that samples ack
	task wb(input logic [7:0] a, input logic w, input logic [31:0] d,
		input logic [3:0] s);
		int n;
		@(posedge clk_i);
		{wb_cyc_i, wb_stb_i, wb_we_i} <= {2'h3, w};
		{wb_adr_i, wb_dat_i, wb_sel_i} <= {a, d, s};
		n = 0;
		do begin
			@(posedge clk_i);
			n++;
		end while (wb_ack_o !== 1'b1 && n < 20);
		if (wb_ack_o !== 1'b1) begin
			n_errors++;
			end_of_test();
		end
		q = wb_dat_o;
		{wb_cyc_i, wb_stb_i} <= 2'h0;
	endtask
	task idle(input int n);
		repeat (n) @(posedge clk_i);
		@(negedge clk_i);
	endtask
	task pulse(input logic [4:0] m);
		@(posedge clk_i);
		{ctrl_lost_i, ctrl_added_i, ctrl_fault_i, bus_fault_i, resync_i} <= m;
		@(posedge clk_i);
		{ctrl_lost_i, ctrl_added_i, ctrl_fault_i, bus_fault_i, resync_i} <= '0;
	endtask
	task log_at(input logic [4:0] i);
		wb(FTL_OFS_LOG_IDX, 1'b1, 32'(i), 4'hF);
		wb(FTL_OFS_LOG_DATA, 1'b0, 32'h0, 4'hF);
	endtask
	task status;
		wb(FTL_OFS_STATUS, 1'b0, 32'h0, 4'hF);
	endtask
	// ----------------------------------------
	// Sequence
	// ----------------------------------------
	initial begin
		repeat (4) @(posedge clk_i);
		rst_i <= 1'b0;
		idle(1);
		chk(32'(&sub_fault_o), 32'h1);
		status();
		chk(q, 32'h0);
		wb(8'hFC, 1'b0, 32'h0, 4'hF);
		chk(q, 32'h0);
		$display("test reset done");
		for (int i = 0; i < 5; i++) begin
			u_ftl_sub_model.stat(8'h05, tab[i][4:1]);
			idle(2);
			chk(32'(sub_fault_o[5]), 32'(tab[i][0]));
		end
		wb(FTL_OFS_SUB_SEL, 1'b1, 32'h5, 4'hF);
		wb(FTL_OFS_SUB_STAT, 1'b0, 32'h0, 4'hF);
		chk(q & 32'h3, 32'h2);
		u_ftl_sub_model.pres(8'h05, 1'b0);
		idle(2);
		chk(32'(sub_fault_o[5]), 32'h1);
		$display("test subscribers done");
		// Upper byte lanes disabled, so only points 0 to 7 are configured
		wb(FTL_OFS_PT_CFG, 1'b1, 32'hFFFF_FFFF, 4'h1);
		pt_consumed_i <= 32'h0000_000F;
		pt_circuit_fault_i <= 32'h0000_0003;
		idle(2);
		chk(point_fault_o, 32'h0000_00F0);
		chk(no_fault_indication_o, 32'hFFFF_FFFC);
		@(posedge clk_i);
		pt_hi_alarm_i <= '1;
		pt_lo_alarm_i <= 32'h0000_FFFF;
		idle(2);
		chk(point_fault_o, 32'h0000_00F0);
		chk(low_alarm_indication_o, 32'h0000_FFFF);
		status();
		chk(q & 32'h0000_3F02, 32'h0);
		$display("test points done");
		wb(FTL_OFS_CTRL, 1'b1, 32'h0000_0031, 4'h1);
		for (int i = 0; i < 40; i++) u_ftl_sub_model.send(4'h5, 8'(i));
		idle(2);
		status();
		chk(32'(q[13:8]), 32'h20);
		chk(32'({io_fault_occurred_flag_o, q[FTL_ST_OVFL],
			log_full_o}), 32'h7);
		chk(32'(u_ftl_sub_model.misses), 32'h0);
		for (int i = 0; i < 32; i++) begin
			log_at(5'(i));
			chk(q, {8'h50, 4'h3, 8'(i < 16 ? i : i + 8), 12'h120});
		end
		wb(FTL_OFS_CTRL, 1'b1, 32'h0000_0131, 4'h3);
		idle(1);
		chk(32'(log_full_o), 32'h0);
		status();
		chk(32'(q[13:8]), 32'h0);
		log_at(5'h0);
		chk(q, 32'h0);
		$display("test log done");
		pulse(5'h1B);
		idle(8);
		chk(32'({controller_lost_flag_o, controller_added_flag_o,
			bus_or_controller_fault_flag_o}), 32'h7);
		for (int i = 0; i < 4; i++) begin
			log_at(5'(i));
			chk(32'(q[31:28]), 32'(types[i]));
		end
		wb(FTL_OFS_STATUS, 1'b1, 32'h0000_007E, 4'h1);
		idle(1);
		chk(32'({controller_lost_flag_o, controller_added_flag_o,
			bus_or_controller_fault_flag_o}), 32'h0);
		pulse(5'h04);
		idle(2);
		chk(32'(bus_or_controller_fault_flag_o), 32'h1);
		wb(FTL_OFS_CTRL, 1'b1, 32'h0000_0030, 4'h1);
		pulse(5'h01);
		idle(6);
		status();
		chk(32'(q[13:8]), 32'h4);
		$display("test events done");
		end_of_test();
	end
endmodule

// File: verification/ftl_checker.sv
`timescale 1ns/10ps
module ftl_checker
	import ftl_pkg::*;
#(
	parameter int NUM_POINTS = 32,
	parameter int NUM_SUBS = 256
) (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// Bus
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	input wire logic wb_ack_o,
	// Events
	input wire logic ctrl_lost_i,
	input wire logic ctrl_added_i,
	input wire logic ctrl_fault_i,
	input wire logic bus_fault_i,
	input wire logic dev_evt_valid_i,
	input wire logic dev_evt_ready_o,
	// Points and subscribers
	input wire logic [NUM_POINTS-1:0] pt_circuit_fault_i,
	input wire logic [NUM_POINTS-1:0] pt_hi_alarm_i,
	input wire logic [NUM_POINTS-1:0] pt_lo_alarm_i,
	input wire logic [NUM_POINTS-1:0] no_fault_indication_o,
	input wire logic [NUM_POINTS-1:0] high_alarm_indication_o,
	input wire logic [NUM_POINTS-1:0] low_alarm_indication_o,
	input wire logic [NUM_SUBS-1:0] sub_fault_o,
	input wire logic bus_controller_unit_fault_o,
	// Flags
	input wire logic log_full_o,
	input wire logic fault_logged_flag_o,
	input wire logic bus_or_controller_fault_flag_o,
	input wire logic controller_lost_flag_o,
	input wire logic controller_added_flag_o
);
	// ----------------------------------------
	// Properties
	// ----------------------------------------
	logic req;
	logic clr;
	// Taken request and clear write decode
	assign req = wb_cyc_i && wb_stb_i && !wb_ack_o;
	assign clr = req && wb_we_i && wb_adr_i == FTL_OFS_CTRL && wb_sel_i[1]
		&& wb_dat_i[FTL_CTRL_CLEAR_BIT];
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);
	property p_ack;
		req |=> wb_ack_o ##1 !wb_ack_o;
	endproperty
	a_ack: assert property (p_ack) else $error("ack not one cycle");
	property p_rst_subs;
		$fell(rst_i) |-> &sub_fault_o;
	endproperty
	a_rst_subs: assert property (p_rst_subs)
		else $error("subscriber fault not set after reset");
	property p_summary;
		bus_controller_unit_fault_o == (|sub_fault_o);
	endproperty
	a_summary: assert property (p_summary)
		else $error("controller summary wrong");
	// Point outputs lag their inputs by one cycle
	property p_nofault;
		!$past(rst_i) |-> no_fault_indication_o == ~$past(pt_circuit_fault_i);
	endproperty
	a_nofault: assert property (p_nofault)
		else $error("no-fault indication wrong");
	property p_alarm;
		!$past(rst_i) |-> high_alarm_indication_o == $past(pt_hi_alarm_i)
			&& low_alarm_indication_o == $past(pt_lo_alarm_i);
	endproperty
	a_alarm: assert property (p_alarm)
		else $error("alarm indication wrong");
	property p_clear;
		clr |=> !log_full_o [*2];
	endproperty
	a_clear: assert property (p_clear)
		else $error("full still set after clear");
	property p_busflag;
		bus_fault_i || ctrl_fault_i |=> bus_or_controller_fault_flag_o;
	endproperty
	a_busflag: assert property (p_busflag)
		else $error("bus or controller flag missing");
	property p_lostadd;
		ctrl_lost_i || ctrl_added_i |=> (!$past(ctrl_lost_i)
			|| controller_lost_flag_o) && (!$past(ctrl_added_i)
			|| controller_added_flag_o);
	endproperty
	a_lostadd: assert property (p_lostadd)
		else $error("lost or added flag missing");
	property p_logged;
		dev_evt_valid_i && dev_evt_ready_o |-> ##[1:3] fault_logged_flag_o;
	endproperty
	a_logged: assert property (p_logged)
		else $error("logged flag missing");
	c_full: cover property ($rose(log_full_o));
	c_take: cover property (dev_evt_valid_i && dev_evt_ready_o);
	c_added: cover property ($rose(controller_added_flag_o));
endmodule
bind ftl_top ftl_checker #(.NUM_POINTS(NUM_POINTS), .NUM_SUBS(NUM_SUBS))
	u_ftl_checker (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i,
	.wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_ack_o, .ctrl_lost_i,
	.ctrl_added_i, .ctrl_fault_i, .bus_fault_i, .dev_evt_valid_i,
	.dev_evt_ready_o, .pt_circuit_fault_i, .pt_hi_alarm_i, .pt_lo_alarm_i,
	.no_fault_indication_o, .high_alarm_indication_o,
	.low_alarm_indication_o, .sub_fault_o, .bus_controller_unit_fault_o,
	.log_full_o, .fault_logged_flag_o, .bus_or_controller_fault_flag_o,
	.controller_lost_flag_o, .controller_added_flag_o);

// File: verification/ftl_sub_model.sv
`timescale 1ns/10ps
module ftl_sub_model (
	// Clock
	input wire logic clk_i,
	// Fault records
	input wire logic ready_i,
	output logic valid_o = 1'b0,
	output logic [3:0] type_o = 4'h0,
	output logic [7:0] sub_o = 8'h00,
	output logic [3:0] rrack_o = 4'h0,
	output logic [3:0] rslot_o = 4'h0,
	// Status and presence
	output logic stat_valid_o = 1'b0,
	output logic [7:0] stat_id_o = 8'h00,
	output logic [3:0] flt_o = 4'h0,
	output logic pres_valid_o = 1'b0,
	output logic [7:0] pres_id_o = 8'h00,
	output logic present_o = 1'b0
);
	// ----------------------------------------
	// Subscriber traffic
	// ----------------------------------------
	// Records never taken; the bench checks this count against zero
	int misses = 0;
	// Record held until ready; released fields inverted so stale data fails
	task automatic send(input logic [3:0] t, input logic [7:0] s);
		int n;
		@(posedge clk_i);
		valid_o <= 1'b1;
		{type_o, sub_o, rrack_o, rslot_o} <= {t, s, 8'h12};
		n = 0;
		do begin
			@(posedge clk_i);
			n++;
		end while (ready_i !== 1'b1 && n < 100);
		if (ready_i !== 1'b1) misses++;
		valid_o <= 1'b0;
		{type_o, sub_o, rrack_o, rslot_o} <= ~{t, s, 8'h12};
	endtask
	// Status word: remote io, bus failure, loss, module fault
	task automatic stat(input logic [7:0] id, input logic [3:0] f);
		@(posedge clk_i);
		stat_valid_o <= 1'b1;
		{stat_id_o, flt_o} <= {id, f};
		@(posedge clk_i);
		stat_valid_o <= 1'b0;
		{stat_id_o, flt_o} <= ~{id, f};
	endtask
	// Presence list entry
	task automatic pres(input logic [7:0] id, input logic p);
		@(posedge clk_i);
		pres_valid_o <= 1'b1;
		{pres_id_o, present_o} <= {id, p};
		@(posedge clk_i);
		pres_valid_o <= 1'b0;
		{pres_id_o, present_o} <= ~{id, p};
	endtask
endmodule

// File: verilog/ftl_log_if.sv
`timescale 1ns/10ps
// Log store port: pushes, clear and indexed read-back
interface ftl_log_if;
	import ftl_pkg::*;
	logic push;
	ftl_rec_t push_data;
	logic clear;
	logic [4:0] rd_idx;
	ftl_rec_t rd_data;
	logic [5:0] count;
	logic full;
	logic dropped;

	modport store (input push, push_data, clear, rd_idx,
		output rd_data, count, full, dropped);
	modport user (output push, push_data, clear, rd_idx,
		input rd_data, count, full, dropped);
endinterface

// File: verilog/ftl_log_store.sv
`timescale 1ns/10ps
module ftl_log_store (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// Log port
	ftl_log_if.store log_if
);
	import ftl_pkg::*;

	ftl_rec_t frozen_reg [FTL_FROZEN_N];
	ftl_rec_t ring_reg [FTL_RING_N];
	logic [4:0] frz_cnt_reg;
	logic [4:0] ring_cnt_reg;
	logic [3:0] head_reg;
	logic [3:0] tail_reg;
	logic frz_open;
	logic ring_full;

	// ----------------------------------------
	// Region selection
	// ----------------------------------------
	assign frz_open = (frz_cnt_reg < 5'(FTL_FROZEN_N));
	assign ring_full = (ring_cnt_reg == 5'(FTL_RING_N));

	// Pointers; clear resets both regions at once
	always_ff @(posedge clk_i) begin
		if (rst_i || log_if.clear) begin
			frz_cnt_reg <= 5'h00;
			ring_cnt_reg <= 5'h00;
			head_reg <= 4'h0;
			tail_reg <= 4'h0;
		end else if (log_if.push) begin
			if (frz_open) begin
				frz_cnt_reg <= 5'(frz_cnt_reg + 5'h01);
			end else if (!ring_full) begin
				ring_cnt_reg <= 5'(ring_cnt_reg + 5'h01);
				tail_reg <= 4'(tail_reg + 4'h1);
			end else begin
				tail_reg <= 4'(tail_reg + 4'h1);
				head_reg <= 4'(head_reg + 4'h1);
			end
		end
	end

	// Record storage; frozen slots are written once per clear
	always_ff @(posedge clk_i) begin
		if (log_if.push && !log_if.clear && !rst_i) begin
			if (frz_open) begin
				frozen_reg[frz_cnt_reg[3:0]] <= log_if.push_data;
			end else begin
				ring_reg[tail_reg] <= log_if.push_data;
			end
		end
	end

	// Overflow pulse: oldest ring record is discarded
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			log_if.dropped <= 1'b0;
		end else begin
			log_if.dropped <= log_if.push && !log_if.clear && !frz_open &&
				ring_full;
		end
	end

	// ----------------------------------------
	// Read-back in logging order
	// ----------------------------------------
	assign log_if.count = 6'(frz_cnt_reg) + 6'(ring_cnt_reg);
	assign log_if.full = (log_if.count == 6'(FTL_LOG_N));

	always_comb begin
		if (6'(log_if.rd_idx) >= log_if.count) begin
			log_if.rd_data = '0;
		end else if (!log_if.rd_idx[4]) begin
			log_if.rd_data = frozen_reg[log_if.rd_idx[3:0]];
		end else begin
			log_if.rd_data = ring_reg[4'(head_reg + log_if.rd_idx[3:0])];
		end
	end

endmodule

// File: verilog/ftl_pkg.sv
package ftl_pkg;

	// ----------------------------------------
	// Log geometry
	// ----------------------------------------
	localparam int FTL_LOG_N = 32;
	localparam int FTL_FROZEN_N = 16;
	localparam int FTL_RING_N = 16;
	localparam int FTL_REC_W = 32;

	// ----------------------------------------
	// Register byte offsets
	// ----------------------------------------
	localparam logic [7:0] FTL_OFS_CTRL = 8'h00;
	localparam logic [7:0] FTL_OFS_STATUS = 8'h04;
	localparam logic [7:0] FTL_OFS_LOG_IDX = 8'h08;
	localparam logic [7:0] FTL_OFS_LOG_DATA = 8'h0C;
	localparam logic [7:0] FTL_OFS_PT_CFG = 8'h10;
	localparam logic [7:0] FTL_OFS_SUB_SEL = 8'h14;
	localparam logic [7:0] FTL_OFS_SUB_STAT = 8'h18;

	// ----------------------------------------
	// Control fields and reset values
	// ----------------------------------------
	localparam int FTL_CTRL_SYNC_BIT = 0;
	localparam int FTL_CTRL_SLOT_LSB = 4;
	localparam int FTL_CTRL_CLEAR_BIT = 8;
	localparam logic [3:0] FTL_SLOT_RST = 4'h0;
	localparam logic [31:0] FTL_PT_CFG_RST = 32'h0000_0000;

	// ----------------------------------------
	// Status bit positions
	// ----------------------------------------
	localparam int FTL_ST_FULL = 0;
	localparam int FTL_ST_LOGGED = 1;
	localparam int FTL_ST_IO_FAULT_OCCURRED_FLAG = 2;
	localparam int FTL_ST_BUS_CTL = 3;
	localparam int FTL_ST_LOST = 4;
	localparam int FTL_ST_ADDED = 5;
	localparam int FTL_ST_OVFL = 6;
	localparam int FTL_ST_CNT_LSB = 8;

	// ----------------------------------------
	// Record layout and fault type codes
	// ----------------------------------------
	localparam logic [3:0] FTL_RACK_ZERO = 4'h0;
	localparam logic [3:0] FTL_T_CTRL_LOST = 4'h1;
	localparam logic [3:0] FTL_T_BUS_FAULT = 4'h2;
	localparam logic [3:0] FTL_T_RESYNC = 4'h3;
	localparam logic [3:0] FTL_T_CTRL_ADDED = 4'h7;

	typedef logic [FTL_REC_W-1:0] ftl_rec_t;

	// Type, rack, slot, subscriber id, remote rack, remote slot
	function automatic ftl_rec_t ftl_make_rec(input logic [3:0] typ,
		input logic [3:0] slot, input logic [7:0] sub,
		input logic [3:0] rrack, input logic [3:0] rslot);
		ftl_make_rec = {typ, FTL_RACK_ZERO, slot, sub, rrack, rslot, 4'h0};
	endfunction

endpackage

// File: verilog/ftl_top.sv
// Implementation choices: the register offsets and register access over Wishbone.
`timescale 1ns/10ps
module ftl_top #(
	parameter int NUM_POINTS = 32,
	parameter int NUM_SUBS = 256
) (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// Wishbone slave
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	// Local controller events, one-cycle pulses
	input wire logic ctrl_lost_i,
	input wire logic ctrl_added_i,
	input wire logic ctrl_fault_i,
	input wire logic bus_fault_i,
	input wire logic resync_i,
	// Remote device fault records
	input wire logic dev_evt_valid_i,
	output logic dev_evt_ready_o,
	input wire logic [3:0] dev_evt_type_i,
	input wire logic [7:0] dev_evt_sub_i,
	input wire logic [3:0] dev_evt_rrack_i,
	input wire logic [3:0] dev_evt_rslot_i,
	// Subscriber status and presence list
	input wire logic sub_stat_valid_i,
	input wire logic [7:0] sub_stat_id_i,
	input wire logic sub_remote_io_i,
	input wire logic sub_bus_fail_i,
	input wire logic sub_lost_i,
	input wire logic sub_module_fault_i,
	input wire logic pres_valid_i,
	input wire logic [7:0] pres_id_i,
	input wire logic pres_present_i,
	// Point validators
	input wire logic [NUM_POINTS-1:0] pt_consumed_i,
	input wire logic [NUM_POINTS-1:0] pt_circuit_fault_i,
	input wire logic [NUM_POINTS-1:0] pt_hi_alarm_i,
	input wire logic [NUM_POINTS-1:0] pt_lo_alarm_i,
	// Indications
	output logic [NUM_POINTS-1:0] point_fault_o,
	output logic [NUM_POINTS-1:0] no_fault_indication_o,
	output logic [NUM_POINTS-1:0] high_alarm_indication_o,
	output logic [NUM_POINTS-1:0] low_alarm_indication_o,
	output logic [NUM_SUBS-1:0] sub_fault_o,
	output logic bus_controller_unit_fault_o,
	// Status flags
	output logic log_full_o,
	output logic fault_logged_flag_o,
	output logic io_fault_occurred_flag_o,
	output logic bus_or_controller_fault_flag_o,
	output logic controller_lost_flag_o,
	output logic controller_added_flag_o
);
	import ftl_pkg::*;

	// ----------------------------------------
	// Parameter checks
	// ----------------------------------------
	if (NUM_POINTS < 1 || NUM_POINTS > 32) begin : g_bad_points
		$error("NUM_POINTS must be 1 to 32");
	end
	if (NUM_SUBS < 1 || NUM_SUBS > 256) begin : g_bad_subs
		$error("NUM_SUBS must be 1 to 256");
	end

	ftl_log_if log_bus ();

	logic sync_mode_reg;
	logic [3:0] slot_reg;
	logic [4:0] log_idx_reg;
	logic [NUM_POINTS-1:0] pt_cfg_reg;
	logic [7:0] sub_sel_reg;
	logic [NUM_SUBS-1:0] sub_fault_reg;
	logic [3:0] pend_reg;
	logic [3:0] pend_next;
	logic [3:0] pend_svc;
	logic logged_reg;
	logic io_fault_occurred_flag_reg;
	logic bus_ctl_reg;
	logic lost_reg;
	logic added_reg;
	logic ovfl_reg;
	logic wb_req;
	logic wr_stb;
	logic rd_sel_sub;
	logic [31:0] status_word;
	logic [31:0] rd_word;
	logic [31:0] w1c;
	logic clear_req;
	logic dev_push;

	// ----------------------------------------
	// Wishbone decode
	// ----------------------------------------
	// One answer per request; ack low for a cycle between requests
	assign wb_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
	assign wr_stb = wb_req && wb_we_i;
	assign w1c = (wr_stb && wb_adr_i == FTL_OFS_STATUS && wb_sel_i[0]) ?
		wb_dat_i : 32'h0000_0000;
	assign clear_req = wr_stb && wb_adr_i == FTL_OFS_CTRL && wb_sel_i[1] &&
		wb_dat_i[FTL_CTRL_CLEAR_BIT];

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wb_ack_o <= 1'b0;
		end else begin
			wb_ack_o <= wb_req;
		end
	end

	// Control register; clear bit is a write-only strobe
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			sync_mode_reg <= 1'b0;
			slot_reg <= FTL_SLOT_RST;
		end else if (wr_stb && wb_adr_i == FTL_OFS_CTRL && wb_sel_i[0]) begin
			sync_mode_reg <= wb_dat_i[FTL_CTRL_SYNC_BIT];
			slot_reg <= wb_dat_i[FTL_CTRL_SLOT_LSB +: 4];
		end
	end

	// Read index into the log
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			log_idx_reg <= 5'h00;
		end else if (wr_stb && wb_adr_i == FTL_OFS_LOG_IDX && wb_sel_i[0]) begin
			log_idx_reg <= wb_dat_i[4:0];
		end
	end

	// Validator configuration per point
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			pt_cfg_reg <= FTL_PT_CFG_RST[NUM_POINTS-1:0];
		end else if (wr_stb && wb_adr_i == FTL_OFS_PT_CFG) begin
			for (int b = 0; b < NUM_POINTS; b++) begin
				if (wb_sel_i[b / 8]) begin
					pt_cfg_reg[b] <= wb_dat_i[b];
				end
			end
		end
	end

	// Subscriber selector for read-back
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			sub_sel_reg <= 8'h00;
		end else if (wr_stb && wb_adr_i == FTL_OFS_SUB_SEL && wb_sel_i[0]) begin
			sub_sel_reg <= wb_dat_i[7:0];
		end
	end

	// ----------------------------------------
	// Read mux; unmapped offsets read zero
	// ----------------------------------------
	assign rd_sel_sub = (32'(sub_sel_reg) < NUM_SUBS) ?
		sub_fault_reg[sub_sel_reg] : 1'b0;

	assign status_word = {16'h0000, 2'b00, log_bus.count, 1'b0, ovfl_reg,
		added_reg, lost_reg, bus_ctl_reg, io_fault_occurred_flag_reg, logged_reg,
		log_bus.full};

	always_comb begin
		unique case (wb_adr_i)
			FTL_OFS_CTRL: rd_word = 32'({slot_reg, 3'b000, sync_mode_reg});
			FTL_OFS_STATUS: rd_word = status_word;
			FTL_OFS_LOG_IDX: rd_word = 32'(log_idx_reg);
			FTL_OFS_LOG_DATA: rd_word = log_bus.rd_data;
			FTL_OFS_PT_CFG: rd_word = 32'(pt_cfg_reg);
			FTL_OFS_SUB_SEL: rd_word = 32'(sub_sel_reg);
			FTL_OFS_SUB_STAT: rd_word = 32'({bus_controller_unit_fault_o,
				rd_sel_sub});
			default: rd_word = 32'h0000_0000;
		endcase
	end

	// Read data held in a register with the ack
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wb_dat_o <= 32'h0000_0000;
		end else if (wb_req && !wb_we_i) begin
			wb_dat_o <= rd_word;
		end
	end

	// ----------------------------------------
	// Local event queue
	// ----------------------------------------
	// Simultaneous lost, bus fault, added and, in sync mode, resync pulses are all kept; ctrl_fault_i is not queued; one record enters per cycle
	always_comb begin
		pend_svc = 4'h0;
		if (pend_reg[0]) begin
			pend_svc = 4'h1;
		end else if (pend_reg[1]) begin
			pend_svc = 4'h2;
		end else if (pend_reg[2]) begin
			pend_svc = 4'h4;
		end else if (pend_reg[3]) begin
			pend_svc = 4'h8;
		end
		pend_next = (pend_reg & ~pend_svc) | {ctrl_added_i,
			resync_i && sync_mode_reg, bus_fault_i, ctrl_lost_i};
	end

	always_ff @(posedge clk_i) begin
		if (rst_i || clear_req) begin
			pend_reg <= 4'h0;
		end else begin
			pend_reg <= pend_next;
		end
	end

	// Remote records wait while a local one is queued
	assign dev_evt_ready_o = (pend_reg == 4'h0) && !clear_req;
	assign dev_push = dev_evt_valid_i && dev_evt_ready_o;

	// ----------------------------------------
	// Log port; alarms have no path here
	// ----------------------------------------
	assign log_bus.clear = clear_req;
	assign log_bus.rd_idx = log_idx_reg;
	assign log_bus.push = (pend_reg != 4'h0 || dev_push) && !clear_req;

	always_comb begin
		unique case (pend_svc)
			4'h1: log_bus.push_data = ftl_make_rec(FTL_T_CTRL_LOST, slot_reg,
				8'h00, 4'h0, 4'h0);
			4'h2: log_bus.push_data = ftl_make_rec(FTL_T_BUS_FAULT, slot_reg,
				8'h00, 4'h0, 4'h0);
			4'h4: log_bus.push_data = ftl_make_rec(FTL_T_RESYNC, slot_reg,
				8'h00, 4'h0, 4'h0);
			4'h8: log_bus.push_data = ftl_make_rec(FTL_T_CTRL_ADDED, slot_reg,
				8'h00, 4'h0, 4'h0);
			default: log_bus.push_data = ftl_make_rec(dev_evt_type_i,
				slot_reg, dev_evt_sub_i, dev_evt_rrack_i,
				dev_evt_rslot_i);
		endcase
	end

	ftl_log_store u_store (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.log_if(log_bus.store)
	);

	// ----------------------------------------
	// Sticky status flags, set beats clear
	// ----------------------------------------
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			logged_reg <= 1'b0;
		end else begin
			logged_reg <= log_bus.push || (logged_reg &&
				!w1c[FTL_ST_LOGGED]);
		end
	end

	// Remote device records count as I/O faults
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			io_fault_occurred_flag_reg <= 1'b0;
		end else begin
			io_fault_occurred_flag_reg <= dev_push || (io_fault_occurred_flag_reg && !w1c[FTL_ST_IO_FAULT_OCCURRED_FLAG]);
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			bus_ctl_reg <= 1'b0;
		end else begin
			bus_ctl_reg <= bus_fault_i || ctrl_fault_i || ctrl_lost_i ||
				(bus_ctl_reg && !w1c[FTL_ST_BUS_CTL]);
		end
	end

	// Lost and added kept apart
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			lost_reg <= 1'b0;
			added_reg <= 1'b0;
		end else begin
			lost_reg <= ctrl_lost_i || (lost_reg && !w1c[FTL_ST_LOST]);
			added_reg <= ctrl_added_i || (added_reg &&
				!w1c[FTL_ST_ADDED]);
		end
	end

	// Overflow marks that a ring record was discarded
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ovfl_reg <= 1'b0;
		end else begin
			ovfl_reg <= log_bus.dropped || (ovfl_reg && !w1c[FTL_ST_OVFL]);
		end
	end

	// ----------------------------------------
	// Subscriber fault indications
	// ----------------------------------------
	// Start faulted: nothing is known until status arrives
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			sub_fault_reg <= '1;
		end else begin
			for (int s = 0; s < NUM_SUBS; s++) begin
				if (sub_stat_valid_i && 32'(sub_stat_id_i) == s) begin
					sub_fault_reg[s] <= sub_bus_fail_i || sub_lost_i ||
						(sub_remote_io_i && sub_module_fault_i);
				end else if (pres_valid_i && 32'(pres_id_i) == s) begin
					if (!pres_present_i) begin
						sub_fault_reg[s] <= 1'b1;
					end else if (!sub_stat_valid_i) begin
						sub_fault_reg[s] <= sub_fault_reg[s];
					end
				end
			end
		end
	end

	assign sub_fault_o = sub_fault_reg;
	assign bus_controller_unit_fault_o = |sub_fault_reg;

	// ----------------------------------------
	// Point indications, registered
	// ----------------------------------------
	// Alarm inputs feed only the alarm outputs
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			point_fault_o <= '0;
			no_fault_indication_o <= '0;
		end else begin
			point_fault_o <= pt_cfg_reg & ~pt_consumed_i;
			no_fault_indication_o <= ~pt_circuit_fault_i;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			high_alarm_indication_o <= '0;
			low_alarm_indication_o <= '0;
		end else begin
			high_alarm_indication_o <= pt_hi_alarm_i;
			low_alarm_indication_o <= pt_lo_alarm_i;
		end
	end

	// ----------------------------------------
	// Flag outputs
	// ----------------------------------------
	assign log_full_o = log_bus.full;
	assign fault_logged_flag_o = logged_reg;
	assign io_fault_occurred_flag_o = io_fault_occurred_flag_reg;
	assign bus_or_controller_fault_flag_o = bus_ctl_reg;
	assign controller_lost_flag_o = lost_reg;
	assign controller_added_flag_o = added_reg;

endmodule
